// ---- core/piel_event_logic.sv ----
`timescale 1ns/1ps
// Function
// RULE_01 - Reset leaves the block in primary mode with nothing for software to set up.
// RULE_02 - Each source has an enable bit in register 30 and a flag in register 29 at one position.
// RULE_03 - In primary mode an enabled source's assert event raises the request.
// RULE_04 - Assert events are rising edges of the sources, except a falling edge for link down.
// RULE_05 - Primary flags clear on the source falling or a read of 29; a read of 1 also clears remote fault.
// RULE_06 - Parallel fault and page flags also clear on a read of 6, a negotiation restart or link loss.
// RULE_07 - The link down flag clears only on reads of 1 or 29, never on the link returning.
// RULE_08 - The link up source is an internal link status not exposed in any register.
// RULE_09 - An energy flag cleared by read while energy stayed high gives a late 256 ms request.
// RULE_10 - Software should clear the energy enable in its service routine to avoid that late request.
// RULE_11 - The energy flag reads 1 after reset and clears soon when no energy is present.
// RULE_12 - Setting the alternate select bit in register 17 switches to alternate mode.
// RULE_13 - In alternate mode software removes the cause first and then writes one to the flag.
// RULE_14 - An alternate write of one clears the flag only if its clear condition holds.
// RULE_15 - The alternate clear condition is the source low, or the link bit high for link down.
// RULE_16 - All enabled flags are combined into one request toward the chip interrupt controller.
// RULE_17 - Both modes raise the request alike and differ only in how it drops; the code arms the late energy request in primary mode only.
module piel_event_logic
    import piel_pkg::*;
#(
    parameter int LATE_DELAY_CYC = PIEL_LATE_DELAY_CYC,
    parameter int LATE_PULSE_CYC = PIEL_LATE_PULSE_CYC
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // Register port from the serial management engine
    input wire logic [4:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [15:0] REG_WDATA_I,
    output logic [15:0] REG_RDATA_O,
    // Status sources
    input wire logic INTERNAL_LINK_UP_STATUS_I,
    input wire logic LINE_ENERGY_PRESENT_I,
    input wire logic AN_COMPLETE_I,
    input wire logic REMOTE_FAULT_I,
    input wire logic LINK_STATUS_I,
    input wire logic LP_ACK_I,
    input wire logic PD_FAULT_I,
    input wire logic PAGE_RX_I,
    input wire logic AN_RESTART_I,
    // Request and its mirror
    output logic IRQ_O,
    output logic TRANSCEIVER_EVENT_BIT_O
);
    // ---------------------------------------------
    // State
    // ---------------------------------------------
    logic [15:0] flags_q, flags_d;
    logic [15:0] enables_q, enables_d;
    logic [15:0] src_q;
    logic alt_q, alt_d;
    logic armed_q, armed_d;
    logic late_active;

    // ---------------------------------------------
    // Source vector and edges
    // ---------------------------------------------
    wire [15:0] src = {6'h00, INTERNAL_LINK_UP_STATUS_I, 1'b0, // RULE_08
                       LINE_ENERGY_PRESENT_I, AN_COMPLETE_I, REMOTE_FAULT_I,
                       LINK_STATUS_I, LP_ACK_I, PD_FAULT_I, PAGE_RX_I, 1'b0};
    wire [15:0] rise = src & ~src_q;
    wire [15:0] fall = ~src & src_q;
    wire [15:0] set_vec = ((rise & ~PIEL_FALL_SET) | (fall & PIEL_FALL_SET))
                          & PIEL_USED_MASK; // RULE_04 RULE_17

    // ---------------------------------------------
    // Access decode
    // ---------------------------------------------
    wire rd1 = REG_RD_I && (REG_ADDR_I == PIEL_IDX_BASIC_STATUS);
    wire rd6 = REG_RD_I && (REG_ADDR_I == PIEL_IDX_AN_EXPANSION);
    wire rd29 = REG_RD_I && (REG_ADDR_I == PIEL_IDX_EVENT_FLAGS);
    wire wr17 = REG_WR_I && (REG_ADDR_I == PIEL_IDX_MODE_CTRL);
    wire wr29 = REG_WR_I && (REG_ADDR_I == PIEL_IDX_EVENT_FLAGS);
    wire wr30 = REG_WR_I && (REG_ADDR_I == PIEL_IDX_EVENT_ENABLES);
    wire link_loss = fall[PIEL_BIT_LINK_DOWN];

    // ---------------------------------------------
    // Clear terms per mode
    // ---------------------------------------------
    wire [15:0] low_clr = ~src & ~PIEL_FALL_SET; // RULE_05
    wire [15:0] pri_clr = low_clr
        | (rd29 ? PIEL_USED_MASK : 16'h0000) // RULE_05
        | (rd1 ? PIEL_RD1_CLR : 16'h0000) // RULE_05 RULE_07
        | ((rd6 || AN_RESTART_I || link_loss) ? PIEL_RD6_CLR : 16'h0000); // RULE_06
    // Link down clears when the link is back up, the rest when low
    wire [15:0] alt_cond = (~src & ~PIEL_FALL_SET) | (src & PIEL_FALL_SET); // RULE_15
    wire [15:0] alt_clr = wr29 ? (REG_WDATA_I & alt_cond) : 16'h0000; // RULE_14
    wire [15:0] clr_vec = (alt_q ? alt_clr : pri_clr) & PIEL_USED_MASK;

    // Set wins over a clear in the same cycle
    assign flags_d = ((flags_q & ~clr_vec) | set_vec) & PIEL_USED_MASK;
    assign enables_d = wr30 ? (REG_WDATA_I & PIEL_USED_MASK) : enables_q; // RULE_02
    assign alt_d = wr17 ? REG_WDATA_I[PIEL_BIT_ALT_SELECT] : alt_q; // RULE_12

    // ---------------------------------------------
    // Late energy request
    // ---------------------------------------------
    // Armed when the flag is read away with energy still present
    wire energy_en = enables_q[PIEL_BIT_ENERGY];
    wire arm = !alt_q && energy_en && rd29 && flags_q[PIEL_BIT_ENERGY]
               && LINE_ENERGY_PRESENT_I; // RULE_09
    wire late_start = armed_q && energy_en && fall[PIEL_BIT_ENERGY];
    assign armed_d = energy_en && !alt_q && (arm || (armed_q && !late_start));

    piel_late_timer #(
        .DELAY_CYC(LATE_DELAY_CYC),
        .PULSE_CYC(LATE_PULSE_CYC)
    ) u_late (
        .clk_i(CORE_CLK_I),
        .rst_i(RST_I),
        .start_i(late_start), // RULE_09
        .cancel_i(!energy_en), // RULE_10
        .active_o(late_active)
    );

    // ---------------------------------------------
    // Request and read data
    // ---------------------------------------------
    wire req_d = (|(flags_d & enables_d)) || late_active; // RULE_16 RULE_03
    wire [15:0] mode_rd = {9'h000, alt_q, 4'h0, LINE_ENERGY_PRESENT_I, 1'b0};
    wire [15:0] rdata_d = (REG_ADDR_I == PIEL_IDX_EVENT_FLAGS) ? flags_q :
                          (REG_ADDR_I == PIEL_IDX_EVENT_ENABLES) ? enables_q :
                          (REG_ADDR_I == PIEL_IDX_MODE_CTRL) ? mode_rd : 16'h0000;

    always_ff @(posedge CORE_CLK_I) begin
        if (RST_I) begin
            flags_q <= PIEL_FLAGS_RST; // RULE_11
            enables_q <= PIEL_ENABLES_RST;
            alt_q <= PIEL_ALT_RST; // RULE_01
            src_q <= '0;
            armed_q <= 1'b0;
            IRQ_O <= 1'b0;
            TRANSCEIVER_EVENT_BIT_O <= 1'b0;
            REG_RDATA_O <= '0;
        end else begin
            flags_q <= flags_d;
            enables_q <= enables_d;
            alt_q <= alt_d;
            src_q <= src;
            armed_q <= armed_d;
            IRQ_O <= req_d;
            TRANSCEIVER_EVENT_BIT_O <= req_d; // RULE_16
            if (REG_RD_I) begin
                REG_RDATA_O <= rdata_d;
            end
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);

    AST_RESET_PRIMARY: assert property ($past(RST_I) |-> !alt_q && flags_q[7]) // RULE_01
        else $error("reset did not give primary mode");
    AST_ENERGY_AT_RESET: assert property ($past(RST_I) |-> flags_q == 16'h0080) // RULE_11
        else $error("energy flag not set after reset");
    AST_REQ_FOLLOWS_FLAGS: assert property ((|(flags_q & enables_q)) |-> IRQ_O) // RULE_03
        else $error("enabled flag without request");
    AST_MASK_GATES: assert property (
        (flags_d & enables_d) == 16'h0000 && !late_active |=> !IRQ_O) // RULE_02
        else $error("request without enabled flag");
    AST_LINK_UP_SETS: assert property (
        $rose(INTERNAL_LINK_UP_STATUS_I) |=> flags_q[9]) // RULE_04
        else $error("link up edge lost");
    AST_RD29_CLEARS: assert property (
        !alt_q && rd29 && set_vec == 16'h0000 |=> flags_q == 16'h0000) // RULE_05
        else $error("primary read did not clear flags");
    AST_LINK_DOWN_STICKS: assert property (
        !alt_q && flags_q[4] && !rd1 && !rd29 |=> flags_q[4]) // RULE_07
        else $error("link down flag cleared without read");
    AST_RESTART_CLEARS: assert property (
        !alt_q && AN_RESTART_I && set_vec[2:1] == 2'b00 |=> flags_q[2:1] == 2'b00) // RULE_06
        else $error("restart did not clear page flags");
    AST_ALT_KEEPS: assert property (
        alt_q && wr29 && REG_WDATA_I[6] && AN_COMPLETE_I && flags_q[6] |=> flags_q[6]) // RULE_14
        else $error("alternate clear with cause present");
    AST_ALT_CLEARS_LINK: assert property (
        alt_q && wr29 && REG_WDATA_I[4] && LINK_STATUS_I && !set_vec[4]
        |=> !flags_q[4]) // RULE_15
        else $error("alternate clear of link down failed");
    AST_ALT_SELECT: assert property (wr17 |=> alt_q == $past(REG_WDATA_I[6])) // RULE_12
        else $error("mode select not taken");
endmodule // piel_event_logic

// ---- core/piel_pkg.sv ----
package piel_pkg;
    // ---------------------------------------------
    // Register indices on the management port
    // ---------------------------------------------
    localparam logic [4:0] PIEL_IDX_BASIC_STATUS = 5'h01;
    localparam logic [4:0] PIEL_IDX_AN_EXPANSION = 5'h06;
    localparam logic [4:0] PIEL_IDX_MODE_CTRL = 5'h11;
    localparam logic [4:0] PIEL_IDX_EVENT_FLAGS = 5'h1d;
    localparam logic [4:0] PIEL_IDX_EVENT_ENABLES = 5'h1e;

    // ---------------------------------------------
    // Bit positions in flag and enable registers
    // ---------------------------------------------
    localparam int PIEL_BIT_PAGE_RX = 1;
    localparam int PIEL_BIT_PD_FAULT = 2;
    localparam int PIEL_BIT_LP_ACK = 3;
    localparam int PIEL_BIT_LINK_DOWN = 4;
    localparam int PIEL_BIT_REMOTE_FAULT = 5;
    localparam int PIEL_BIT_AN_DONE = 6;
    localparam int PIEL_BIT_ENERGY = 7;
    localparam int PIEL_BIT_LINK_UP = 9;
    localparam logic [15:0] PIEL_USED_MASK = 16'h02fe;
    localparam logic [15:0] PIEL_RD1_CLR = 16'h0030;
    localparam logic [15:0] PIEL_RD6_CLR = 16'h0006;
    localparam logic [15:0] PIEL_FALL_SET = 16'h0010;

    // ---------------------------------------------
    // Mode control register fields
    // ---------------------------------------------
    localparam int PIEL_BIT_ALT_SELECT = 6;
    localparam int PIEL_BIT_LINE_ENERGY = 1;

    // ---------------------------------------------
    // Reset values
    // ---------------------------------------------
    localparam logic [15:0] PIEL_FLAGS_RST = 16'h0080;
    localparam logic [15:0] PIEL_ENABLES_RST = 16'h0000;
    localparam logic PIEL_ALT_RST = 1'b0;

    // ---------------------------------------------
    // Timing
    // ---------------------------------------------
    localparam int PIEL_CLK_MHZ = 200;
    localparam int PIEL_LATE_DELAY_MS = 1000;
    localparam int PIEL_LATE_PULSE_MS = 256;
    localparam int PIEL_LATE_DELAY_CYC = PIEL_LATE_DELAY_MS * 1000 * PIEL_CLK_MHZ;
    localparam int PIEL_LATE_PULSE_CYC = PIEL_LATE_PULSE_MS * 1000 * PIEL_CLK_MHZ;
    localparam int PIEL_CNT_W = 28;

    typedef enum logic [1:0] {
        PIEL_T_IDLE = 2'b00,
        PIEL_T_WAIT = 2'b01,
        PIEL_T_PULSE = 2'b11
    } piel_timer_e;
endpackage

// ---- core/piel_late_timer.sv ----
`timescale 1ns/1ps
module piel_late_timer
    import piel_pkg::*;
#(
    parameter int DELAY_CYC = PIEL_LATE_DELAY_CYC,
    parameter int PULSE_CYC = PIEL_LATE_PULSE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic cancel_i,
    output logic active_o
);
    // ---------------------------------------------
    // Elaboration check
    // ---------------------------------------------
    if (DELAY_CYC < 1 || PULSE_CYC < 1 || DELAY_CYC >= (1 << PIEL_CNT_W)
        || PULSE_CYC >= (1 << PIEL_CNT_W)) begin : g_chk
        $error("piel_late_timer: counts out of range");
    end

    piel_timer_e state_q, state_d;
    logic [PIEL_CNT_W-1:0] cnt_q, cnt_d;
    wire cnt_done = (cnt_q == '0);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - 1'b1;
        unique case (state_q)
            PIEL_T_IDLE: begin
                if (start_i) begin
                    state_d = PIEL_T_WAIT;
                    cnt_d = PIEL_CNT_W'(DELAY_CYC - 1);
                end
            end
            PIEL_T_WAIT: begin
                if (cnt_done) begin
                    state_d = PIEL_T_PULSE;
                    cnt_d = PIEL_CNT_W'(PULSE_CYC - 1);
                end
            end
            PIEL_T_PULSE: begin
                if (cnt_done) begin
                    state_d = PIEL_T_IDLE;
                end
            end
            default: begin
                state_d = PIEL_T_IDLE;
            end
        endcase
        // Clearing the enable drops a pending late request
        if (cancel_i) begin
            state_d = PIEL_T_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= PIEL_T_IDLE;
            cnt_q <= '0;
            active_o <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            active_o <= (state_d == PIEL_T_PULSE);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_LATE_WAIT_FIRST: assert property ( // RULE_09
        (state_q == PIEL_T_IDLE && start_i && !cancel_i) |=> !active_o [*2])
        else $error("late request came without the delay");
    AST_LATE_PULSE_HOLDS: assert property ( // RULE_09
        ($rose(active_o) && PULSE_CYC > 4 && !cancel_i) |=> (active_o || $past(cancel_i)))
        else $error("late request pulse ended early");
endmodule // piel_late_timer

// ---- tb/piel_mgmt_model.sv ----
`timescale 1ns/1ps
module piel_mgmt_model (
    input wire logic clk_i,
    output logic [4:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o,
    input wire logic [15:0] rdata_i
);
    initial begin
        addr_o = 5'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
    end
    // Strobe spans one rising edge; data inverted once released
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule // piel_mgmt_model

// ---- tb/tb_piel_event_logic.sv ----
`timescale 1ns/1ps
module tb_piel_event_logic;
    import piel_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic restart = 1'b0;
    logic [15:0] src = 16'h0090;
    logic [4:0] addr;
    logic wr, rd, irq, evbit;
    logic [15:0] wdata, rdata, v, en;
    int bad_count = 0;
    int compares = 0;
    int hi, first;
    int bits[8] = '{9, 7, 6, 5, 4, 3, 2, 1};
    always #2.5 clk = ~clk;
    piel_mgmt_model mgmt (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata));
    piel_event_logic #(.LATE_DELAY_CYC(20), .LATE_PULSE_CYC(10)) DUT (
        .CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
        .INTERNAL_LINK_UP_STATUS_I(src[9]), .LINE_ENERGY_PRESENT_I(src[7]),
        .AN_COMPLETE_I(src[6]), .REMOTE_FAULT_I(src[5]), .LINK_STATUS_I(src[4]),
        .LP_ACK_I(src[3]), .PD_FAULT_I(src[2]), .PAGE_RX_I(src[1]),
        .AN_RESTART_I(restart), .IRQ_O(irq), .TRANSCEIVER_EVENT_BIT_O(evbit));
    function automatic logic [15:0] onehot(input int b);
        return 16'h0001 << b;
    endfunction
    // Link down is active low, every other source active high
    function automatic logic active(input int b);
        return (b == PIEL_BIT_LINK_DOWN) ? 1'b0 : 1'b1;
    endfunction
    task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e);
        chk16({n, " irq"}, {15'h0000, e}, {15'h0000, irq});
        chk16({n, " mirror"}, {15'h0000, e}, {15'h0000, evbit});
    endtask
    task automatic step();
        @(negedge clk);
    endtask
    task automatic rdchk(input string n, input logic [4:0] a, input logic [15:0] e);
        mgmt.rd(a, v);
        chk16(n, e, v);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #400000;
        bad_count++;
        results();
    end
    initial begin
        void'($urandom(34474));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        // ---------------------------------------------
        // Reset values and enable register
        // ---------------------------------------------
        chk1("reset", 1'b0);
        rdchk("flags rst", PIEL_IDX_EVENT_FLAGS, 16'h0080);
        rdchk("mode rst", PIEL_IDX_MODE_CTRL, 16'h0002);
        rdchk("en rst", PIEL_IDX_EVENT_ENABLES, 16'h0000);
        mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'hffff);
        rdchk("en mask", PIEL_IDX_EVENT_ENABLES, 16'h02fe);
        mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'h0000);
        src[7] = 1'b0;
        $display("test reset done");
        // ---------------------------------------------
        // Primary mode: each source, random enables
        // ---------------------------------------------
        foreach (bits[i]) begin
            en = 16'($urandom) & PIEL_USED_MASK;
            mgmt.wr(PIEL_IDX_EVENT_ENABLES, en);
            src[bits[i]] = active(bits[i]);
            step();
            step();
            chk1("assert", en[bits[i]]);
            if (bits[i] == PIEL_BIT_LINK_DOWN) begin
                src[4] = 1'b1;
                step();
                chk1("link back", en[4]);
            end
            rdchk("flag", PIEL_IDX_EVENT_FLAGS, onehot(bits[i]));
            chk1("read clr", 1'b0);
            mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'h0000);
            src[bits[i]] = ~active(bits[i]);
        end
        $display("test primary done");
        // ---------------------------------------------
        // Other primary clear causes
        // ---------------------------------------------
        for (int k = 0; k < 5; k++) begin
            hi = (k == 0) ? 6 : (k == 1) ? 5 : (k == 3) ? 2 : 1;
            src[hi] = 1'b1;
            step();
            step();
            if (k == 0) src[hi] = 1'b0;
            if (k == 1) mgmt.rd(PIEL_IDX_BASIC_STATUS, v);
            if (k == 2) mgmt.rd(PIEL_IDX_AN_EXPANSION, v);
            if (k == 3) restart = 1'b1;
            if (k == 4) src[4] = 1'b0;
            step();
            restart = 1'b0;
            rdchk("cleared", PIEL_IDX_EVENT_FLAGS, (k == 4) ? onehot(4) : 16'h0000);
            src[hi] = 1'b0;
            src[4] = 1'b1;
        end
        $display("test clear causes done");
        // ---------------------------------------------
        // Late energy request after read-away flag
        // ---------------------------------------------
        mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'h0080);
        src[7] = 1'b1;
        step();
        step();
        chk1("energy", 1'b1);
        rdchk("energy flag", PIEL_IDX_EVENT_FLAGS, 16'h0080);
        chk1("energy read", 1'b0);
        src[7] = 1'b0;
        hi = 0;
        first = 0;
        for (int c = 1; c <= 60; c++) begin
            step();
            if (irq === 1'b1 && hi == 0) first = c;
            if (irq === 1'b1) hi++;
        end
        chk16("late len", 16'd10, 16'(hi));
        chk16("late start ok", 16'h0001, {15'h0000, first >= 19 && first <= 24});
        rdchk("late no flag", PIEL_IDX_EVENT_FLAGS, 16'h0000);
        mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'h0000);
        $display("test late energy done");
        // ---------------------------------------------
        // Alternate mode write-one clear
        // ---------------------------------------------
        mgmt.wr(PIEL_IDX_MODE_CTRL, 16'h0040);
        rdchk("mode alt", PIEL_IDX_MODE_CTRL, 16'h0040);
        mgmt.wr(PIEL_IDX_EVENT_ENABLES, 16'h0050);
        src[6] = 1'b1;
        step();
        step();
        mgmt.wr(PIEL_IDX_EVENT_FLAGS, 16'h0040);
        chk1("alt busy", 1'b1);
        rdchk("alt read", PIEL_IDX_EVENT_FLAGS, 16'h0040);
        src[6] = 1'b0;
        step();
        chk1("alt fall", 1'b1);
        mgmt.wr(PIEL_IDX_EVENT_FLAGS, 16'h0040);
        chk1("alt clr", 1'b0);
        src[4] = 1'b0;
        step();
        step();
        mgmt.wr(PIEL_IDX_EVENT_FLAGS, 16'h0010);
        chk1("alt link low", 1'b1);
        src[4] = 1'b1;
        step();
        chk1("alt link high", 1'b1);
        mgmt.wr(PIEL_IDX_EVENT_FLAGS, 16'h0010);
        chk1("alt link clr", 1'b0);
        $display("test alternate done");
        // ---------------------------------------------
        // Second reset returns to primary mode
        // ---------------------------------------------
        rst = 1'b1;
        step();
        step();
        rst = 1'b0;
        rdchk("mode rst2", PIEL_IDX_MODE_CTRL, 16'h0000);
        rdchk("en rst2", PIEL_IDX_EVENT_ENABLES, 16'h0000);
        chk1("rst2", 1'b0);
        $display("test second reset done");
        results();
    end
endmodule // tb_piel_event_logic
